// File: verilog/osc_trim_pkg.sv
package osc_trim_pkg;

  // ===================================================================
  // register map (word offsets are byte addresses)
  // ===================================================================
  localparam logic [7:0] OFF_OSC_TRIM = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CAPTURE = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_FACTORY = 8'h18;
  localparam logic [7:0] OFF_ADJUST = 8'h1C;

  // ===================================================================
  // fields
  // ===================================================================
  localparam int TRIM3_W = 3;
  localparam int TRIM4_W = 4;
  localparam int ADJ_W = 8;
  localparam int CNT_W = 16;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PSC_LSB = 1;
  localparam int CTRL_FLT_LSB = 4;
  localparam int CTRL_CCO_BIT = 8;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CAP_BIT = 1;

  // ===================================================================
  // reset values
  // ===================================================================
  localparam logic [3:0] TRIM_RESET = 4'h0;
  localparam logic [1:0] PSC_RESET = 2'h0;
  localparam logic [3:0] FLT_RESET = 4'h3;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [3:0] FLT_DEFAULT_SAMPLES = 4'h8;

  // ===================================================================
  // states
  // ===================================================================
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } trim_state_t;

endpackage

// File: verilog/capture_link_if.sv
`default_nettype none
interface capture_link_if;
  logic [3:0] filter_setting;
  logic raw_sync;
  logic filtered;
  modport ctl (output filter_setting, output raw_sync, input filtered);
  modport flt (input filter_setting, input raw_sync, output filtered);
endinterface
`default_nettype wire

// File: verilog/capture_filter.sv
`default_nettype none
module capture_filter
  import osc_trim_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  capture_link_if.flt link
);

  // ===================================================================
  // sample counter filter
  // ===================================================================
  logic [4:0] run_q;
  logic [4:0] run_d;
  logic out_q;
  logic out_d;
  logic [4:0] need;

  // setting 0 passes every sample; setting n needs n+5 equal samples
  always_comb begin
    need = (link.filter_setting == 4'h0) ? 5'h01
         : 5'({1'b0, link.filter_setting} + 5'h05);
    out_d = out_q;
    run_d = run_q;
    if (link.raw_sync == out_q) begin
      run_d = 5'h00;
    end else if (5'(run_q + 5'h01) >= need) begin
      out_d = link.raw_sync;
      run_d = 5'h00;
    end else begin
      run_d = 5'(run_q + 5'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 5'h00;
      out_q <= 1'b0;
    end else begin
      run_q <= run_d;
      out_q <= out_d;
    end
  end

  assign link.filtered = out_q;

endmodule
`default_nettype wire

// File: verilog/osc_trim_capture.sv
// The register addresses and register access over Wishbone were decided locally.
`default_nettype none
module osc_trim_capture
  import osc_trim_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic trim_width_option_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic factory_valid_i,
  output logic factory_rd_o,
  input wire logic capture_input_pin_i,
  output logic [7:0] osc_adjust_o,
  output logic clock_out_pin_o,
  output logic irq_o
);

  // ===================================================================
  // declarations
  // ===================================================================
  trim_state_t state_q;
  trim_state_t state_d;
  logic [7:0] factory_q;
  logic [7:0] factory_d;
  logic wide_q;
  logic wide_d;
  logic [3:0] trim_q;
  logic [3:0] trim_d;
  logic en_q;
  logic en_d;
  logic [1:0] psc_q;
  logic [1:0] psc_d;
  logic [3:0] flt_q;
  logic [3:0] flt_d;
  logic cco_q;
  logic cco_d;
  logic [1:0] irq_st_q;
  logic [1:0] irq_st_d;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_mask_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cap_q;
  logic [CNT_W-1:0] cap_d;
  logic [2:0] edge_cnt_q;
  logic [2:0] edge_cnt_d;
  logic filt_prev_q;
  logic [7:0] adjust_q;
  logic [7:0] adjust_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] pin_sync_q;
  logic req;
  logic wr;
  logic wr_lane0;
  logic wr_lane1;
  logic rise;
  logic cap_evt;
  logic ovf_evt;
  logic [7:0] trim_ext;

  capture_link_if link ();

  // ===================================================================
  // helpers
  // ===================================================================
  function automatic logic hit(input logic [31:0] adr,
                               input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]) && (adr[31:8] == 24'h000000);
  endfunction

  function automatic logic [2:0] psc_mask(input logic [1:0] sel);
    unique case (sel)
      2'h0: psc_mask = 3'h0;
      2'h1: psc_mask = 3'h1;
      2'h2: psc_mask = 3'h3;
      2'h3: psc_mask = 3'h7;
    endcase
  endfunction

  // ===================================================================
  // capture pin synchroniser and filter
  // ===================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], capture_input_pin_i};
    end
  end

  assign link.raw_sync = pin_sync_q[1];
  assign link.filter_setting = flt_q;

  capture_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .link(link)
  );

  // ===================================================================
  // bus decode
  // ===================================================================
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;
  assign wr_lane0 = wr && wb_sel_i[0];
  assign wr_lane1 = wr && wb_sel_i[1];

  // ===================================================================
  // factory load sequence
  // ===================================================================
  always_comb begin
    state_d = state_q;
    factory_d = factory_q;
    wide_d = wide_q;
    unique case (state_q)
      ST_LOAD: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (factory_valid_i) begin
          factory_d = factory_trim_i;
          wide_d = trim_width_option_i;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_LOAD;
      factory_q <= 8'h00;
      wide_q <= 1'b0;
    end else begin
      state_q <= state_d;
      factory_q <= factory_d;
      wide_q <= wide_d;
    end
  end

  assign factory_rd_o = (state_q == ST_WAIT);

  // ===================================================================
  // trim and adjustment
  // ===================================================================
  // sign-extend the active field
  assign trim_ext = wide_q ? {{4{trim_q[3]}}, trim_q}
                           : {{5{trim_q[2]}}, trim_q[2:0]};

  always_comb begin
    trim_d = trim_q;
    if (wr_lane0 && hit(wb_adr_i, OFF_OSC_TRIM)) begin
      trim_d = wide_q ? wb_dat_i[3:0]
                      : {1'b0, wb_dat_i[2:0]};
    end
    // oscillator runs slower as the adjustment grows
    adjust_d = 8'(factory_q + trim_ext);
    if (state_q != ST_RUN) begin
      adjust_d = factory_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_q <= TRIM_RESET;
      adjust_q <= 8'h00;
    end else begin
      trim_q <= trim_d;
      adjust_q <= adjust_d;
    end
  end

  assign osc_adjust_o = adjust_q;

  // ===================================================================
  // timer, prescaler, capture
  // ===================================================================
  assign rise = link.filtered && !filt_prev_q;
  assign cap_evt = en_q && rise
                && ((edge_cnt_q & psc_mask(psc_q)) == 3'h0);
  assign ovf_evt = en_q && (cnt_q == 16'hFFFF);

  always_comb begin
    cnt_d = cnt_q;
    cap_d = cap_q;
    edge_cnt_d = edge_cnt_q;
    if (en_q) begin
      cnt_d = 16'(cnt_q + 16'h0001);
    end
    if (en_q && rise) begin
      edge_cnt_d = 3'(edge_cnt_q + 3'h1);
    end
    if (!en_q) begin
      edge_cnt_d = 3'h0;
    end
    if (cap_evt) begin
      cap_d = cnt_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
      cap_q <= 16'h0000;
      edge_cnt_q <= 3'h0;
      filt_prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      cap_q <= cap_d;
      edge_cnt_q <= edge_cnt_d;
      filt_prev_q <= link.filtered;
    end
  end

  // ===================================================================
  // control and interrupt registers
  // ===================================================================
  always_comb begin
    en_d = en_q;
    psc_d = psc_q;
    flt_d = flt_q;
    cco_d = cco_q;
    irq_mask_d = irq_mask_q;
    irq_st_d = irq_st_q;
    if (wr_lane0 && hit(wb_adr_i, OFF_CTRL)) begin
      en_d = wb_dat_i[CTRL_EN_BIT];
      psc_d = wb_dat_i[CTRL_PSC_LSB +: 2];
      flt_d = wb_dat_i[CTRL_FLT_LSB +: 4];
    end
    if (wr_lane1 && hit(wb_adr_i, OFF_CTRL)) begin
      cco_d = wb_dat_i[CTRL_CCO_BIT];
    end
    if (wr_lane0 && hit(wb_adr_i, OFF_IRQ_MASK)) begin
      irq_mask_d = wb_dat_i[1:0];
    end
    if (wr_lane0 && hit(wb_adr_i, OFF_IRQ_STATUS)) begin
      irq_st_d = irq_st_q & ~wb_dat_i[1:0];
    end
    // set wins over a same-cycle clear
    if (ovf_evt) begin
      irq_st_d[IRQ_OVF_BIT] = 1'b1;
    end
    if (cap_evt) begin
      irq_st_d[IRQ_CAP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      psc_q <= PSC_RESET;
      flt_q <= FLT_RESET;
      cco_q <= 1'b0;
      irq_mask_q <= IRQ_MASK_RESET;
      irq_st_q <= 2'h0;
    end else begin
      en_q <= en_d;
      psc_q <= psc_d;
      flt_q <= flt_d;
      cco_q <= cco_d;
      irq_mask_q <= irq_mask_d;
      irq_st_q <= irq_st_d;
    end
  end

  assign irq_o = |(irq_st_q & irq_mask_q);
  assign clock_out_pin_o = cco_q & clk_i;

  // ===================================================================
  // read data and acknowledge
  // ===================================================================
  always_comb begin
    rdata_d = 32'h00000000;
    if (hit(wb_adr_i, OFF_OSC_TRIM)) begin
      rdata_d = wide_q ? {28'h0, trim_q}
                       : {29'h0, trim_q[2:0]};
    end else if (hit(wb_adr_i, OFF_CTRL)) begin
      rdata_d = {23'h0, cco_q, flt_q, 1'b0, psc_q, en_q};
    end else if (hit(wb_adr_i, OFF_COUNT)) begin
      rdata_d = {16'h0000, cnt_q};
    end else if (hit(wb_adr_i, OFF_CAPTURE)) begin
      rdata_d = {16'h0000, cap_q};
    end else if (hit(wb_adr_i, OFF_IRQ_STATUS)) begin
      rdata_d = {30'h0, irq_st_q};
    end else if (hit(wb_adr_i, OFF_IRQ_MASK)) begin
      rdata_d = {30'h0, irq_mask_q};
    end else if (hit(wb_adr_i, OFF_FACTORY)) begin
      rdata_d = {23'h0, wide_q, factory_q};
    end else if (hit(wb_adr_i, OFF_ADJUST)) begin
      rdata_d = {24'h000000, adjust_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      rdata_q <= req ? rdata_d : rdata_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule
`default_nettype wire

// File: test/osc_trim_props.sv
`default_nettype none
module osc_trim_props
  import osc_trim_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic trim_width_option_i,
  input wire logic [7:0] factory_trim_i,
  input wire logic factory_valid_i,
  input wire logic factory_rd_o,
  input wire logic capture_input_pin_i,
  input wire logic [7:0] osc_adjust_o,
  input wire logic clock_out_pin_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==================================================================
  // bus and load sequences
  // ==================================================================
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence load_s;
    factory_rd_o && factory_valid_i;
  endsequence
  ack_after_take_a: assert property (take_s |=> wb_ack_o)
    else $error("bus request not acknowledged");
  ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[7:0] >= 8'h20 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  trim_upper_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[7:0] == OFF_OSC_TRIM
    |-> wb_dat_o[31:4] == 28'h0)
    else $error("trim upper bits not zero");
  reset_quiet_a: assert property (
    $fell(rst_i) |-> !wb_ack_o && !irq_o && osc_adjust_o == 8'h00)
    else $error("outputs not cleared by reset");
  factory_wait_a: assert property ($fell(rst_i) |-> ##[1:4] factory_rd_o)
    else $error("factory load not requested");
  factory_done_a: assert property (load_s |=> !factory_rd_o)
    else $error("factory request not dropped");
  adjust_load_a: assert property (
    load_s |-> ##[1:2] osc_adjust_o == factory_trim_i)
    else $error("adjust not loaded from factory value");
  irq_clear_write_a: assert property ($fell(irq_o) |->
    (wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i))
    else $error("interrupt dropped without a write");
endmodule
bind osc_trim_capture osc_trim_props osc_trim_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .trim_width_option_i(trim_width_option_i),
  .factory_trim_i(factory_trim_i), .factory_valid_i(factory_valid_i),
  .factory_rd_o(factory_rd_o), .capture_input_pin_i(capture_input_pin_i),
  .osc_adjust_o(osc_adjust_o), .clock_out_pin_o(clock_out_pin_o),
  .irq_o(irq_o));
`default_nettype wire

// File: test/ref_square_wave.sv
`default_nettype none
module ref_square_wave (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [15:0] half_i,
  output var logic wave_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  // ==================================================================
  // reference timebase, low while stopped
  // ==================================================================
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt_q <= 16'h0000;
      wave_o <= 1'b0;
    end else if (cnt_q == 16'(half_i - 16'h0001)) begin
      cnt_q <= 16'h0000;
      wave_o <= ~wave_o;
    end else begin
      cnt_q <= 16'(cnt_q + 16'h0001);
    end
  end
endmodule
`default_nettype wire

// File: test/test_osc_trim_capture.sv
`default_nettype none
module test_osc_trim_capture
  import osc_trim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FACT = 8'h40;
  localparam int HALF = 20;
  logic clk_i, rst_i, wb_we, wb_cyc, wb_stb, opt, fvalid, run, wave;
  logic [31:0] wb_adr, wb_wdat;
  logic [31:0] wb_rdat;
  logic wb_ack, frd, cko, irq_o;
  logic [7:0] osc_adjust_o;
  int n_mismatch, n_tests, n_cyc;
  osc_trim_capture osc_trim_capture_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_sel_i(4'hF), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_ack_o(wb_ack), .trim_width_option_i(opt), .factory_trim_i(FACT),
    .factory_valid_i(fvalid), .factory_rd_o(frd),
    .capture_input_pin_i(wave), .osc_adjust_o(osc_adjust_o),
    .clock_out_pin_o(cko), .irq_o(irq_o));
  ref_square_wave ref_square_wave_inst (.clk_i(clk_i), .run_i(run),
    .half_i(16'(HALF)), .wave_o(wave));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 95000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==================================================================
  // helpers
  // ==================================================================
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr <= {24'h000000, a};
    wb_wdat <= d;
    wb_we <= w;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1);
    chk(32'(n), 32'h2);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, irq_o}, 32'h1);
  endtask
  // ==================================================================
  // scenarios
  // ==================================================================
  task automatic do_reset(input logic wide);
    logic [31:0] q;
    @(posedge clk_i);
    rst_i <= 1'b1;
    fvalid <= 1'b0;
    opt <= wide;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    fvalid <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({24'h0, osc_adjust_o}, {24'h0, FACT});
    wb(1'b0, OFF_OSC_TRIM, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, OFF_ADJUST, 32'h0, q);
    chk(q, {24'h0, FACT});
  endtask
  task automatic trim_sweep(input int w);
    logic [31:0] q;
    int s;
    for (int v = 0; v < (1 << w); v++) begin
      wr(OFF_OSC_TRIM, (32'hFFFFFFFF << w) | 32'(v));
      wb(1'b0, OFF_OSC_TRIM, 32'h0, q);
      chk(q, 32'(v));
      s = (v >= (1 << (w - 1))) ? v - (1 << w) : v;
      chk({24'h0, osc_adjust_o}, {24'h0, 8'(int'(FACT) + s)});
    end
  endtask
  task automatic clock_out();
    wr(OFF_CTRL, 32'h100);
    @(posedge clk_i);
    #2 chk({31'h0, cko}, 32'h1);
    @(negedge clk_i);
    #2 chk({31'h0, cko}, 32'h0);
    wr(OFF_CTRL, 32'h0);
    @(posedge clk_i);
    #2 chk({31'h0, cko}, 32'h0);
  endtask
  task automatic capture_irq();
    logic [31:0] q;
    @(posedge clk_i);
    run <= 1'b1;
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_CTRL, 32'h31);
    wb(1'b0, OFF_CTRL, 32'h0, q);
    chk(q, 32'h31);
    repeat (100) @(posedge clk_i);
    wb(1'b0, OFF_IRQ_STATUS, 32'h0, q);
    chk(q & 32'h2, 32'h2);
    chk({31'h0, irq_o}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h2);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_IRQ_STATUS, 32'h3);
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic period_check(input int p);
    logic [31:0] c1, c2;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_IRQ_STATUS, 32'h3);
    wr(OFF_CTRL, 32'h31 | 32'(p << 1));
    wait_irq(2000);
    wb(1'b0, OFF_CAPTURE, 32'h0, c1);
    wr(OFF_IRQ_STATUS, 32'h2);
    wait_irq(2000);
    wb(1'b0, OFF_CAPTURE, 32'h0, c2);
    chk((c2 - c1) & 32'hFFFF, 32'(2 * HALF) << p);
  endtask
  task automatic overflow();
    logic [31:0] q;
    run <= 1'b0;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_IRQ_STATUS, 32'h3);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CTRL, 32'h1);
    wait_irq(70000);
    wb(1'b0, OFF_IRQ_STATUS, 32'h0, q);
    chk(q, 32'h1);
  endtask
  initial begin
    logic [31:0] q;
    rst_i = 1'b1;
    wb_we = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_adr = 32'h0;
    wb_wdat = 32'h0;
    opt = 1'b0;
    fvalid = 1'b0;
    run = 1'b0;
    n_cyc = 0;
    do_reset(1'b0);
    trim_sweep(3);
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    clock_out();
    capture_irq();
    for (int p = 0; p < 4; p++) period_check(p);
    overflow();
    do_reset(1'b1);
    wb(1'b0, OFF_FACTORY, 32'h0, q);
    chk(q, {23'h0, 1'b1, FACT});
    trim_sweep(4);
    stop_test();
  end
endmodule
`default_nettype wire
